// ===== hw/sapm_regs.svh
// Purpose: Offsets, reset values and pin positions of the pin mux
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef SAPM_REGS_SVH
`define SAPM_REGS_SVH
// ==========================================================
// Register offsets
`define SAPM_P17_FSEL_OFS   12'h000
`define SAPM_P18_FSEL_OFS   12'h004
`define SAPM_P18_EXT_OFS    12'h008
`define SAPM_CH_EN_OFS      12'h00C
`define SAPM_P17_DATA_OFS   12'h010
`define SAPM_P17_DIR_OFS    12'h014
`define SAPM_P18_DATA_OFS   12'h018
`define SAPM_P18_DIR_OFS    12'h01C
`define SAPM_PIN_STAT_OFS   12'h020
// ==========================================================
// Second converter register window
`define SAPM_CONV_LO        12'h5E0
`define SAPM_CONV_HI        12'h5EB
// ==========================================================
// Reset values and widths
`define SAPM_BYTE_RST       8'h00
`define SAPM_CH_EN_RST      15'h0000
`define SAPM_CH_EN_W        15
// Implemented pins of port 18 (bits 3 and 7 absent)
`define SAPM_P18_IMPL       8'h77
// First channel of the second converter
`define SAPM_CH_BASE        32
`endif

// ===== hw/sapm_pkg.sv
// Purpose: Types shared by the pin mux files
// Assumes: Nothing
// Notes:   Bus slave states are one-hot
package sapm_pkg;
	// ==========================================================
	// Bus slave states
	typedef enum logic [2:0]
	{
		SAPM_IDLE = 3'b001,
		SAPM_CONV = 3'b010,
		SAPM_DONE = 3'b100
	} sapm_state_e;
	typedef logic [7:0] sapm_byte_t;
endpackage

// ===== hw/sapm_pin_cell.sv
// Purpose: One pad slice: output select, driver enable, input shutdown
// Assumes: Pad input synchronous to pclk
// Notes:   Analog enable shuts both input stage and driver
`timescale 1ns/100ps
module sapm_pin_cell
#(
	parameter bit IMPL = 1'b1
)
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Selection
	input  wire logic alt_sel,
	input  wire logic analog_en,
	input  wire logic gpio_out,
	input  wire logic gpio_dir,
	input  wire logic alt_out,
	input  wire logic alt_drive,
	// Pad
	input  wire logic pad_in,
	output logic      pad_out_ff,
	output logic      pad_oe_n_ff,
	output logic      din_ff
);
	logic nxt_drive;
	// ==========================================================
	// Driver select
	always_comb
	begin
		nxt_drive = IMPL && !analog_en && (alt_sel ? alt_drive : gpio_dir);
	end
	// Pad output and enable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pad_out_ff  <= 1'b0;
			pad_oe_n_ff <= 1'b1;
		end
		else
		begin
			pad_out_ff  <= alt_sel ? alt_out : gpio_out;
			pad_oe_n_ff <= !nxt_drive;
		end
	end
	// Input stage, tied low while shut down
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			din_ff <= 1'b0;
		else
			din_ff <= IMPL && !analog_en && pad_in;
	end
endmodule // sapm_pin_cell

// ===== hw/sapm_pin_mux.sv
// Purpose: Pin mux of ports 17/18 and trigger routing, second converter
// Assumes: APB slave on pclk, pads synchronous, converter outside
// Notes:   Converter registers are bridged through a request port
`timescale 1ns/100ps
`include "sapm_regs.svh"
// Overview of operation
// RQ1: Port 17 select at 0 makes every port 17 pin a GPIO bit.
// RQ2: Port 17 select at 1 puts pulse timer outputs 7..0 on pins 7..0.
// RQ3: Port 18 select at 0 makes pins 0,1,2,4,5,6 GPIO bits.
// RQ4: Select 1, extended 0: pins carry LIN 6 and 7 in, out, clock.
// RQ5: Both selects 1: pins feed up/down counters 2,3 and free-run clocks 6,7.
// RQ6: Channels 34-39 on port 17 pins 2-7, 42 and 46 on port 18 pins 2, 6.
// RQ7: Channel n is enabled by channel-enable bit n minus 32.
// RQ8: Analog connection depends only on the channel-enable bit.
// RQ9: An enabled analog channel shuts the pin's digital input stage.
// RQ10: External conversion trigger comes from port 16 pin 7, shared.
// RQ11: Internal conversion trigger comes from reload timer 7, shared.
// RQ12: Second converter is the same 10-bit macro with the same registers.
// RQ13: Converter registers sit at 0x5E0 through 0x5EB.
// RQ14: Enables reach only listed pins; port 17 pins 0,1 have no analog.
// RQ15: Clearing an enable restores the input and the selected function.
module sapm_pin_mux
	import sapm_pkg::*;
(
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic                    pready,
	output logic [31:0]             prdata,
	output logic                    pslverr,
	// Second converter register port
	output logic                    conv_sel,
	output logic                    conv_write,
	output logic [3:0]              conv_index,
	output logic [31:0]             conv_wdata,
	input  wire logic               conv_ready,
	input  wire logic [31:0]        conv_rdata,
	// Second converter channels and triggers
	output logic [14:0]             second_converter_channel_enable,
	output logic [7:0]              analog_connect,
	input  wire logic               conversion_trigger_input,
	input  wire logic               reload7_trigger,
	output logic                    second_ext_trigger,
	output logic                    second_int_trigger,
	// Port 17 pads
	input  wire logic [7:0]         p17_in,
	output logic [7:0]              p17_out,
	output logic [7:0]              p17_oe_n,
	// Port 18 pads
	input  wire logic [7:0]         p18_in,
	output logic [7:0]              p18_out,
	output logic [7:0]              p18_oe_n,
	// Pulse generator timer outputs
	input  wire logic [7:0]         pulse_generator_timer,
	// LIN channels 6 and 7, index 0 is channel 6
	input  wire logic [1:0]         lin_serial_out,
	input  wire logic [1:0]         lin_clock_out,
	input  wire logic [1:0]         lin_clock_drive,
	output logic                    lin6_serial_in,
	output logic                    lin7_serial_in,
	output logic                    lin6_clock_in,
	output logic                    lin7_clock_in,
	// Up/down counters and free-run timers
	output logic                    updown2_input_a,
	output logic                    updown2_input_b,
	output logic                    updown2_input_z,
	output logic                    updown3_input_a,
	output logic                    updown3_input_b,
	output logic                    updown3_input_z,
	output logic                    freerun6_clock_in,
	output logic                    freerun7_clock_in
);
	// ==========================================================
	// Declarations
	sapm_byte_t         p17_fsel_ff;
	sapm_byte_t         p18_fsel_ff;
	sapm_byte_t         p18_ext_ff;
	sapm_byte_t         p17_data_ff;
	sapm_byte_t         p17_dir_ff;
	sapm_byte_t         p18_data_ff;
	sapm_byte_t         p18_dir_ff;
	logic [14:0]        ch_en_ff;
	sapm_state_e        state_ff;
	logic [7:0]         din17;
	logic [7:0]         din18;
	logic [7:0]         an17;
	logic [7:0]         an18;
	logic [7:0]         alt18_out;
	logic [7:0]         alt18_drive;
	logic               acc;
	logic               in_conv;
	logic               hit;
	logic               commit;
	logic [31:0]        nxt_rdata;

	// Analog pin to channel-enable bit; -1 when the pin has none
	function automatic int ch_of(input int port, input int pin);
		if (port == 17 && pin >= 2)
			return 32 + pin - `SAPM_CH_BASE; // RQ7
		else if (port == 18 && (pin == 2 || pin == 6))
			return 40 + pin - `SAPM_CH_BASE; // RQ7
		else
			return -1; // RQ14
	endfunction

	// ==========================================================
	// APB decode
	assign acc     = psel && penable;
	assign in_conv = (paddr >= `SAPM_CONV_LO) && (paddr <= `SAPM_CONV_HI); // RQ13
	assign commit  = acc && pready && pwrite && hit && !in_conv;

	// Local read mux and hit
	always_comb
	begin
		hit       = 1'b1;
		nxt_rdata = 32'h0000_0000;
		case (paddr)
			`SAPM_P17_FSEL_OFS: nxt_rdata = {24'h00_0000, p17_fsel_ff};
			`SAPM_P18_FSEL_OFS: nxt_rdata = {24'h00_0000, p18_fsel_ff};
			`SAPM_P18_EXT_OFS:  nxt_rdata = {24'h00_0000, p18_ext_ff};
			`SAPM_CH_EN_OFS:    nxt_rdata = {17'h0_0000, ch_en_ff};
			`SAPM_P17_DATA_OFS: nxt_rdata = {24'h00_0000, p17_data_ff};
			`SAPM_P17_DIR_OFS:  nxt_rdata = {24'h00_0000, p17_dir_ff};
			`SAPM_P18_DATA_OFS: nxt_rdata = {24'h00_0000, p18_data_ff};
			`SAPM_P18_DIR_OFS:  nxt_rdata = {24'h00_0000, p18_dir_ff};
			`SAPM_PIN_STAT_OFS: nxt_rdata = {16'h0000, din18, din17};
			default:            hit = 1'b0;
		endcase
	end

	// Bus slave sequencing and converter bridge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff   <= SAPM_IDLE;
			pready     <= 1'b0;
			prdata     <= 32'h0000_0000;
			pslverr    <= 1'b0;
			conv_sel   <= 1'b0;
			conv_write <= 1'b0;
			conv_index <= 4'h0;
			conv_wdata <= 32'h0000_0000;
		end
		else
		begin
			case (state_ff)
				SAPM_IDLE:
				begin
					if (acc && in_conv)
					begin
						conv_sel   <= 1'b1; // RQ13
						conv_write <= pwrite;
						conv_index <= 4'(paddr - `SAPM_CONV_LO);
						conv_wdata <= pwdata;
						state_ff   <= SAPM_CONV;
					end
					else if (acc)
					begin
						pready   <= 1'b1;
						prdata   <= pwrite ? 32'h0000_0000 : nxt_rdata;
						pslverr  <= !hit;
						state_ff <= SAPM_DONE;
					end
				end
				SAPM_CONV:
				begin
					if (conv_ready)
					begin
						conv_sel <= 1'b0;
						pready   <= 1'b1;
						prdata   <= conv_write ? 32'h0000_0000 : conv_rdata; // RQ12
						pslverr  <= 1'b0;
						state_ff <= SAPM_DONE;
					end
				end
				SAPM_DONE:
				begin
					pready   <= 1'b0;
					pslverr  <= 1'b0;
					state_ff <= SAPM_IDLE;
				end
				default:
				begin
					pready   <= 1'b0;
					conv_sel <= 1'b0;
					state_ff <= SAPM_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Control registers, written at the completing edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			p17_fsel_ff <= `SAPM_BYTE_RST;
			p18_fsel_ff <= `SAPM_BYTE_RST;
			p18_ext_ff  <= `SAPM_BYTE_RST;
			p17_data_ff <= `SAPM_BYTE_RST;
			p17_dir_ff  <= `SAPM_BYTE_RST;
			p18_data_ff <= `SAPM_BYTE_RST;
			p18_dir_ff  <= `SAPM_BYTE_RST;
			ch_en_ff    <= `SAPM_CH_EN_RST;
		end
		else if (commit)
		begin
			case (paddr)
				`SAPM_P17_FSEL_OFS: p17_fsel_ff <= pwdata[7:0];
				`SAPM_P18_FSEL_OFS: p18_fsel_ff <= pwdata[7:0];
				`SAPM_P18_EXT_OFS:  p18_ext_ff  <= pwdata[7:0];
				`SAPM_CH_EN_OFS:    ch_en_ff    <= pwdata[`SAPM_CH_EN_W-1:0]; // RQ7
				`SAPM_P17_DATA_OFS: p17_data_ff <= pwdata[7:0];
				`SAPM_P17_DIR_OFS:  p17_dir_ff  <= pwdata[7:0];
				`SAPM_P18_DATA_OFS: p18_data_ff <= pwdata[7:0];
				`SAPM_P18_DIR_OFS:  p18_dir_ff  <= pwdata[7:0];
				default:            ;
			endcase
		end
	end

	// ==========================================================
	// Pad slices; analog enable ignores both selects
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_pin
			localparam int C17 = ch_of(17, gi);
			localparam int C18 = ch_of(18, gi);
			localparam logic [7:0] P18_IMPL = `SAPM_P18_IMPL;
			assign an17[gi] = (C17 >= 0) ? ch_en_ff[C17 < 0 ? 0 : C17] : 1'b0; // RQ8
			assign an18[gi] = (C18 >= 0) ? ch_en_ff[C18 < 0 ? 0 : C18] : 1'b0; // RQ8
			// LIN lanes: 0 in, 1 out, 2 clock; counters only take inputs
			assign alt18_out[gi]   = ((gi % 4) == 1) ? lin_serial_out[gi / 4]
				: lin_clock_out[gi / 4];
			assign alt18_drive[gi] = p18_ext_ff[gi] ? 1'b0 // RQ5
				: ((gi % 4) == 1) ? 1'b1 // RQ4
				: ((gi % 4) == 2) ? lin_clock_drive[gi / 4] : 1'b0;
			// Port 17: GPIO or pulse timer
			sapm_pin_cell #(.IMPL(1'b1)) u_p17
			(
				.pclk        (pclk),
				.presetn     (presetn),
				.alt_sel     (p17_fsel_ff[gi]), // RQ1 RQ2
				.analog_en   (an17[gi]), // RQ9 RQ15
				.gpio_out    (p17_data_ff[gi]),
				.gpio_dir    (p17_dir_ff[gi]),
				.alt_out     (pulse_generator_timer[gi]),
				.alt_drive   (1'b1),
				.pad_in      (p17_in[gi]),
				.pad_out_ff  (p17_out[gi]),
				.pad_oe_n_ff (p17_oe_n[gi]),
				.din_ff      (din17[gi])
			);
			// Port 18: GPIO, LIN or counter inputs
			sapm_pin_cell #(.IMPL(P18_IMPL[gi])) u_p18
			(
				.pclk        (pclk),
				.presetn     (presetn),
				.alt_sel     (p18_fsel_ff[gi]), // RQ3
				.analog_en   (an18[gi]), // RQ9 RQ15
				.gpio_out    (p18_data_ff[gi]),
				.gpio_dir    (p18_dir_ff[gi]),
				.alt_out     (alt18_out[gi]),
				.alt_drive   (alt18_drive[gi]),
				.pad_in      (p18_in[gi]),
				.pad_out_ff  (p18_out[gi]),
				.pad_oe_n_ff (p18_oe_n[gi]),
				.din_ff      (din18[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Analog connection and channel enables to the converter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			analog_connect                  <= 8'h00;
			second_converter_channel_enable <= `SAPM_CH_EN_RST;
		end
		else
		begin
			analog_connect <= {an18[6], an18[2], an17[7:2]}; // RQ6 RQ14
			second_converter_channel_enable <= ch_en_ff; // RQ7
		end
	end

	// Shared conversion triggers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			second_ext_trigger <= 1'b0;
			second_int_trigger <= 1'b0;
		end
		else
		begin
			second_ext_trigger <= conversion_trigger_input; // RQ10
			second_int_trigger <= reload7_trigger; // RQ11
		end
	end

	// LIN inputs, idle high serial line when not selected
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lin6_serial_in <= 1'b1;
			lin7_serial_in <= 1'b1;
			lin6_clock_in  <= 1'b0;
			lin7_clock_in  <= 1'b0;
		end
		else
		begin
			lin6_serial_in <= (p18_fsel_ff[0] && !p18_ext_ff[0]) ? din18[0] : 1'b1; // RQ4
			lin7_serial_in <= (p18_fsel_ff[4] && !p18_ext_ff[4]) ? din18[4] : 1'b1; // RQ4
			lin6_clock_in  <= p18_fsel_ff[2] && !p18_ext_ff[2] && din18[2];
			lin7_clock_in  <= p18_fsel_ff[6] && !p18_ext_ff[6] && din18[6];
		end
	end

	// Counter and free-run clock inputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			updown2_input_a   <= 1'b0;
			updown2_input_b   <= 1'b0;
			updown2_input_z   <= 1'b0;
			updown3_input_a   <= 1'b0;
			updown3_input_b   <= 1'b0;
			updown3_input_z   <= 1'b0;
			freerun6_clock_in <= 1'b0;
			freerun7_clock_in <= 1'b0;
		end
		else
		begin
			updown2_input_a   <= p18_fsel_ff[0] && p18_ext_ff[0] && din18[0]; // RQ5
			updown2_input_b   <= p18_fsel_ff[1] && p18_ext_ff[1] && din18[1];
			updown2_input_z   <= p18_fsel_ff[2] && p18_ext_ff[2] && din18[2];
			updown3_input_a   <= p18_fsel_ff[4] && p18_ext_ff[4] && din18[4];
			updown3_input_b   <= p18_fsel_ff[5] && p18_ext_ff[5] && din18[5];
			updown3_input_z   <= p18_fsel_ff[6] && p18_ext_ff[6] && din18[6];
			freerun6_clock_in <= p18_fsel_ff[2] && p18_ext_ff[2] && din18[2]; // RQ5
			freerun7_clock_in <= p18_fsel_ff[6] && p18_ext_ff[6] && din18[6];
		end
	end

	// ==========================================================
	// Assertions
	AST_P17_GPIO: // RQ1
	assert property (@(posedge pclk) disable iff (!presetn)
		(!p17_fsel_ff[0] && p17_dir_ff[0])
		|=> (!p17_oe_n[0] && p17_out[0] == $past(p17_data_ff[0])))
	else $error("port 17 pin 0 not driven as GPIO");

	AST_P17_PULSE: // RQ2
	assert property (@(posedge pclk) disable iff (!presetn)
		p17_fsel_ff[1]
		|=> (!p17_oe_n[1] && p17_out[1] == $past(pulse_generator_timer[1])))
	else $error("port 17 pin 1 not carrying pulse timer");

	AST_P18_GPIO: // RQ3
	assert property (@(posedge pclk) disable iff (!presetn)
		!p18_fsel_ff[0] |=> (p18_oe_n[0] == !$past(p18_dir_ff[0])))
	else $error("port 18 pin 0 direction wrong");

	AST_P18_LIN_OUT: // RQ4
	assert property (@(posedge pclk) disable iff (!presetn)
		(p18_fsel_ff[5] && !p18_ext_ff[5])
		|=> (!p18_oe_n[5] && p18_out[5] == $past(lin_serial_out[1])))
	else $error("lin 7 serial out not on port 18 pin 5");

	AST_P18_COUNTER: // RQ5
	assert property (@(posedge pclk) disable iff (!presetn)
		(p18_fsel_ff[4] && p18_ext_ff[4]) ##1 (p18_fsel_ff[4] && p18_ext_ff[4])
		|=> (updown3_input_a == $past(p18_in[4], 2) && p18_oe_n[4]))
	else $error("counter 3 input a does not follow pin");

	AST_ANALOG_MAP: // RQ6
	assert property (@(posedge pclk) disable iff (!presetn)
		##1 (analog_connect[7] == $past(ch_en_ff[14])
		&& analog_connect[0] == $past(ch_en_ff[2])))
	else $error("analog connection mapping wrong");

	AST_INPUT_SHUT: // RQ9
	assert property (@(posedge pclk) disable iff (!presetn)
		ch_en_ff[10] |=> (!din18[2] && p18_oe_n[2]))
	else $error("digital input active on analog pin");

	AST_PERIPH_SHUT: // RQ9
	assert property (@(posedge pclk) disable iff (!presetn)
		ch_en_ff[10] ##1 ch_en_ff[10]
		|=> (!updown2_input_z && !freerun6_clock_in && !lin6_clock_in))
	else $error("peripheral input active on analog pin");

	AST_EXT_TRIGGER: // RQ10
	assert property (@(posedge pclk) disable iff (!presetn)
		##1 second_ext_trigger == $past(conversion_trigger_input))
	else $error("external trigger not routed");

	AST_APB_PULSE: // RQ13
	assert property (@(posedge pclk) disable iff (!presetn)
		(acc && in_conv && state_ff == SAPM_IDLE) |=> (conv_sel && !pready))
	else $error("converter window not bridged");
endmodule // sapm_pin_mux

// ===== verification/test_sapm_pin_mux.sv
// Purpose: Self-checking bench of the port 17/18 pin mux and trigger routing
// Assumes: Pads are looped back: a driven pin reads its own output level
// Notes:   Driver queues expected results, a watcher pops them as results appear
`timescale 1ns/100ps
`include "sapm_regs.svh"
module test_sapm_pin_mux;
	import sapm_pkg::*;
	// ==========================================================
	// Signals
	typedef struct {int what; logic [63:0] exp; logic [63:0] mask;} sapm_note_s;
	localparam logic [32:0] wr_m  = 33'h1_0000_0000;
	localparam logic [32:0] all_m = 33'h1_FFFF_FFFF;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, probe;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, conv_wdata, conv_rdata;
	logic        conv_sel, conv_write, conv_ready;
	logic [3:0]  conv_index;
	logic [1:0]  conv_wait, lin_serial_out, lin_clock_out, lin_clock_drive;
	logic [14:0] second_converter_channel_enable, v;
	logic [7:0]  analog_connect, p17_in, p17_out, p17_oe_n, p18_in, p18_out, p18_oe_n;
	logic [7:0]  pulse_generator_timer, p17_x, p18_x;
	logic        conversion_trigger_input, reload7_trigger, second_ext_trigger;
	logic        second_int_trigger, lin6_serial_in, lin7_serial_in, lin6_clock_in;
	logic        lin7_clock_in, updown2_input_a, updown2_input_b, updown2_input_z;
	logic        updown3_input_a, updown3_input_b, updown3_input_z;
	logic        freerun6_clock_in, freerun7_clock_in, lin, updown_counter;
	logic [7:0]  fs17, d17, d18, a17, a18, g17, g18, o17, o18, oe18, om, cdm, pad18;
	logic [11:0] pe, pm;
	logic [31:0] conv_mem [16];
	logic [31:0] cw [3];
	int          k, mode, cycles, compares, n_mismatch;
	sapm_note_s  notes [$];
	sapm_note_s  cur;
	// Pad wires: the pin shows the design level while driven, else the far side
	assign p17_in = (~p17_oe_n & p17_out) | (p17_oe_n & p17_x);
	assign p18_in = (~p18_oe_n & p18_out) | (p18_oe_n & p18_x);
	// ==========================================================
	// Design
	sapm_pin_mux i_dut
	(
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .conv_sel, .conv_write, .conv_index, .conv_wdata, .conv_ready,
		.conv_rdata, .second_converter_channel_enable, .analog_connect,
		.conversion_trigger_input, .reload7_trigger, .second_ext_trigger,
		.second_int_trigger, .p17_in, .p17_out, .p17_oe_n, .p18_in, .p18_out, .p18_oe_n,
		.pulse_generator_timer, .lin_serial_out, .lin_clock_out, .lin_clock_drive,
		.lin6_serial_in, .lin7_serial_in, .lin6_clock_in, .lin7_clock_in,
		.updown2_input_a, .updown2_input_b, .updown2_input_z, .updown3_input_a,
		.updown3_input_b, .updown3_input_z, .freerun6_clock_in, .freerun7_clock_in
	);
	// ==========================================================
	// Tasks
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One APB transfer, expected {pslverr, prdata} noted first
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e, input logic [32:0] m);
		notes.push_back('{0, 64'(e), 64'(m)});
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Ask the watcher to sample one group of outputs
	task automatic look(input int w, input logic [63:0] e, input logic [63:0] m);
		notes.push_back('{w, e, m});
		probe <= 1'b1;
		@(posedge pclk);
		probe <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ==========================================================
	// Clock and timeout
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			n_mismatch++;
			end_sim();
		end
	end
	// Converter side: random latency, returns stored word with its index
	always @(posedge pclk)
	begin
		if (conv_sel === 1'b1 && conv_ready === 1'b0 && conv_wait == 2'h0)
		begin
			conv_ready <= 1'b1;
			conv_rdata <= {conv_mem[conv_index][27:0], conv_index};
			if (conv_write === 1'b1)
				conv_mem[conv_index] <= conv_wdata;
			conv_wait <= 2'($urandom);
		end
		else
		begin
			conv_ready <= 1'b0;
			conv_rdata <= ~conv_rdata;
			if (conv_sel === 1'b1 && conv_ready === 1'b0)
				conv_wait <= conv_wait - 2'h1;
		end
	end
	// Watcher: pops the oldest note whenever a result appears
	always @(posedge pclk)
	begin
		if (presetn === 1'b1 && (pready === 1'b1 || probe === 1'b1))
		begin
			if (notes.size() == 0)
			begin
				n_mismatch++;
				$display("CHECK FAILED t=%0t unexpected result", $time);
			end
			else
			begin
				cur = notes.pop_front();
				case (cur.what)
					0: check({31'h0, pslverr, prdata} & cur.mask, cur.exp & cur.mask);
					1: check({48'h0, p17_oe_n, p17_out} & cur.mask, cur.exp & cur.mask);
					2: check({48'h0, p18_oe_n, p18_out} & cur.mask, cur.exp & cur.mask);
					3: check({52'h0, lin6_serial_in, lin7_serial_in, lin6_clock_in, lin7_clock_in,
						updown2_input_a, updown2_input_b, updown2_input_z, updown3_input_a,
						updown3_input_b, updown3_input_z, freerun6_clock_in, freerun7_clock_in}
						& cur.mask, cur.exp & cur.mask);
					default: check({39'h0, second_converter_channel_enable, analog_connect,
						second_ext_trigger, second_int_trigger}, cur.exp);
				endcase
			end
		end
	end
	// ==========================================================
	// Main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, probe, conv_ready, conv_wait} = '0;
		{paddr, pwdata, conv_rdata, p17_x, p18_x, pulse_generator_timer} = '0;
		{lin_serial_out, lin_clock_out, lin_clock_drive} = '0;
		{conversion_trigger_input, reload7_trigger} = '0;
		void'($urandom(29));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (k = 0; k < 9; k++)
			apb(1'b0, 12'(4 * k), 32'h0, 33'h0, all_m);
		look(1, 64'hFF00, 64'hFFFF);
		look(2, 64'hFF00, 64'hFFFF);
		look(3, 64'hC00, 64'hFFF);
		look(4, 64'h0, '1);
		$display("test reset values done");
		apb(1'b0, 12'h024, 32'h0, {1'b1, 32'h0}, all_m);
		apb(1'b1, 12'h024, 32'h5A, {1'b1, 32'h0}, wr_m);
		apb(1'b0, 12'h5EC, 32'h0, {1'b1, 32'h0}, all_m);
		$display("test unmapped access done");
		for (k = 0; k < 3; k++)
		begin
			cw[k] = $urandom;
			apb(1'b1, `SAPM_CONV_LO + 12'(4 * k), cw[k], 33'h0, wr_m);
		end
		for (k = 0; k < 3; k++)
			apb(1'b0, `SAPM_CONV_LO + 12'(4 * k), 32'h0, {1'b0, cw[k][27:0], 4'(4 * k)}, all_m);
		$display("test converter window done");
		apb(1'b1, `SAPM_P17_DIR_OFS, 32'hFF, 33'h0, wr_m);
		apb(1'b1, `SAPM_P18_DIR_OFS, 32'hFF, 33'h0, wr_m);
		for (k = 0; k < 9; k++)
		begin
			fs17 = 8'($urandom);
			d17  = 8'($urandom);
			d18  = 8'($urandom);
			v    = (k == 8) ? 15'h0000 : 15'($urandom);
			mode = k % 3;
			p17_x <= 8'($urandom);
			p18_x <= 8'($urandom);
			pulse_generator_timer <= 8'($urandom);
			lin_serial_out <= 2'($urandom);
			lin_clock_out <= 2'($urandom);
			lin_clock_drive <= 2'($urandom);
			conversion_trigger_input <= 1'($urandom);
			reload7_trigger <= 1'($urandom);
			apb(1'b1, `SAPM_P17_FSEL_OFS, {24'h0, fs17}, 33'h0, wr_m);
			apb(1'b1, `SAPM_P18_FSEL_OFS, (mode == 0) ? 32'h0 : 32'h77, 33'h0, wr_m);
			apb(1'b1, `SAPM_P18_EXT_OFS, (mode == 2) ? 32'h77 : 32'h0, 33'h0, wr_m);
			apb(1'b1, `SAPM_P17_DATA_OFS, {24'h0, d17}, 33'h0, wr_m);
			apb(1'b1, `SAPM_P18_DATA_OFS, {24'h0, d18}, 33'h0, wr_m);
			apb(1'b1, `SAPM_CH_EN_OFS, {17'h0, v}, 33'h0, wr_m);
			repeat (3) @(posedge pclk);
			// Expected pins from the selects, analog enables and far-side levels
			lin  = (mode == 1);
			updown_counter  = (mode == 2);
			a17  = {v[7:2], 2'b00};
			a18  = {1'b0, v[14], 3'b000, v[10], 2'b00};
			cdm  = {1'b0, lin_clock_drive[1], 3'b000, lin_clock_drive[0], 2'b00};
			o17  = (fs17 & pulse_generator_timer) | (~fs17 & d17);
			o18  = lin ? {1'b0, lin_clock_out[1], lin_serial_out[1], 2'b00,
				lin_clock_out[0], lin_serial_out[0], 1'b0} : d18;
			om   = (updown_counter ? 8'h00 : lin ? (8'h22 | cdm) : 8'h77) & ~a18;
			oe18 = updown_counter ? 8'hFF : lin ? (8'hDD & ~cdm) | 8'h88 | a18 : 8'h88 | a18;
			pad18 = (~oe18 & o18) | (oe18 & p18_x);
			g17  = o17 & ~a17;
			g18  = pad18 & ~a18;
			pe   = {lin ? {g18[0], g18[4], g18[2], g18[6]} : 4'b1100, updown_counter ? {g18[0], g18[1],
				g18[2], g18[4], g18[5], g18[6], g18[2], g18[6]} : 8'h00};
			pm   = {2'b11, ~(lin & lin_clock_drive[0]), ~(lin & lin_clock_drive[1]), 8'hFF};
			look(1, {48'h0, a17, o17}, {48'h0, 8'hFF, ~a17});
			look(2, {48'h0, oe18, o18}, {48'h0, 8'hFF, om});
			look(3, {52'h0, pe}, {52'h0, pm});
			look(4, {39'h0, v, v[14], v[10], v[7:2], conversion_trigger_input,
				reload7_trigger}, '1);
			apb(1'b0, `SAPM_CH_EN_OFS, 32'h0, {18'h0, v}, all_m);
			apb(1'b0, `SAPM_P17_FSEL_OFS, 32'h0, {25'h0, fs17}, all_m);
			apb(1'b0, `SAPM_PIN_STAT_OFS, 32'h0, {17'h0, g18, g17}, 33'h1_0000_77FF);
			$display("test mux pass %0d mode %0d done", k, mode);
		end
		repeat (2) @(posedge pclk);
		check(64'(notes.size()), 64'h0);
		end_sim();
	end
endmodule // test_sapm_pin_mux
